// File: hdl/ofc_flash_ctrl.sv
// top: AHB-Lite slave and erase/program sequencer for the on-chip flash
// assumes an interconnect that decodes i_hsel for the flash region
`timescale 1ns/1ps
module ofc_flash_ctrl (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_erase_req,
  input  wire logic        i_program_req,
  input  wire logic [4:0]  i_op_sector,
  input  wire logic [3:0]  i_op_row,
  input  wire logic        i_unprotect,
  input  wire logic        i_protect,
  input  wire logic        i_lock,
  input  wire logic [4:0]  i_prot_sector,
  output logic             o_busy,
  output logic             o_done,
  output logic      [31:0] o_protected,
  output logic      [31:0] o_locked
);
  ofc_mem_if #(.AW(ofc_pkg::ARR_AW)) arr_if ();
  ofc_mem_if #(.AW(ofc_pkg::BUF_AW)) buf_if ();

  ofc_mem #(.AW(ofc_pkg::ARR_AW)) u_array (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .port       (arr_if.mem)
  );

  ofc_mem #(.AW(ofc_pkg::BUF_AW)) u_page_buf (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .port       (buf_if.mem)
  );

  // byte lanes of a little-endian transfer
  function automatic logic [3:0] lanes(input logic [2:0] size, input logic [1:0] a);
    logic [3:0] m;
    m = 4'hf;
    if (size == ofc_pkg::HSIZE_BYTE) begin
      m = 4'h1 << a;
    end else if (size == ofc_pkg::HSIZE_HALF) begin
      m = a[1] ? 4'hc : 4'h3;
    end
    return m;
  endfunction

  // sector may be changed only if inside the application area and free
  function automatic logic may_modify(input logic [4:0] s, input logic [31:0] p,
                                      input logic [31:0] l);
    return (s < ofc_pkg::APP_SEC_LIM) && !p[s] && !l[s];
  endfunction

  ofc_pkg::ofc_state_t state;
  logic [7:0]  cnt;
  logic [4:0]  op_sector;
  logic [3:0]  op_row;
  logic        dp_pend;
  logic        dp_wr;
  logic        dp_write;
  logic [12:0] dp_addr;
  logic [3:0]  dp_be;
  logic        err_second;

  wire         idle       = (state == ofc_pkg::OFC_IDLE);
  wire         acc        = i_hsel && i_hready && i_htrans[1];
  wire [14:0]  off        = i_haddr[14:0];
  // accesses past the application area answer with an error
  wire         out_of_app = (off >= ofc_pkg::APP_LIMIT);
  wire         start      = idle && !dp_pend && (i_erase_req || i_program_req);
  wire         busy_now   = !idle || start;
  wire         acc_ok     = acc && !out_of_app;
  wire         acc_stall  = acc_ok && busy_now;
  wire         resolve    = dp_pend && idle;
  // permission sampled when the operation is taken
  wire         allowed    = may_modify(i_op_sector, o_protected, o_locked);
  wire         erase_end  = (state == ofc_pkg::OFC_ERASE) && (cnt == ofc_pkg::ERASE_LAST);
  wire         prog_end   = (state == ofc_pkg::OFC_PROG_WR) && (cnt[3:0] == ofc_pkg::PROG_LAST);
  wire         buf_wr     = dp_wr || (resolve && dp_write);

  // contiguous word addressing, lanes kept little-endian
  wire [12:0]  seq_addr   = (state == ofc_pkg::OFC_ERASE) ? {op_sector, cnt} :
                            {op_sector, op_row, cnt[3:0]};
  assign arr_if.addr  = !idle   ? seq_addr :
                        dp_pend ? dp_addr  : off[14:2];
  // erase writes the erased pattern, program can only clear bits
  assign arr_if.wdata = (state == ofc_pkg::OFC_ERASE) ? ofc_pkg::ERASED_WORD :
                        (arr_if.rdata & buf_if.rdata);
  assign arr_if.be    = 4'hf;
  // only the sequencer ever writes the array
  assign arr_if.we    = (state == ofc_pkg::OFC_ERASE) || (state == ofc_pkg::OFC_PROG_WR);

  // buffer indexed by low word-address bits
  assign buf_if.addr  = (state == ofc_pkg::OFC_PROG_RD) ? cnt[3:0] : dp_addr[3:0];
  assign buf_if.wdata = i_hwdata;
  assign buf_if.be    = dp_be;
  assign buf_if.we    = buf_wr;

  assign o_hrdata     = arr_if.rdata;

  wire [7:0]   next_cnt   = (start || erase_end || prog_end) ? 8'h00 :
                            (state == ofc_pkg::OFC_PROG_RD) ? cnt :
                            idle ? cnt : 8'(cnt + 8'h01);

  // sequencer for the two separate operations
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ofc_pkg::OFC_IDLE;
    end else begin
      case (state)
        ofc_pkg::OFC_IDLE: begin
          // refused operations end quietly with no error
          if (start && allowed) begin
            state <= i_erase_req ? ofc_pkg::OFC_ERASE : ofc_pkg::OFC_PROG_RD;
          end
        end
        ofc_pkg::OFC_ERASE: begin
          if (erase_end) begin
            state <= ofc_pkg::OFC_IDLE;
          end
        end
        ofc_pkg::OFC_PROG_RD: begin
          state <= ofc_pkg::OFC_PROG_WR;
        end
        ofc_pkg::OFC_PROG_WR: begin
          state <= prog_end ? ofc_pkg::OFC_IDLE : ofc_pkg::OFC_PROG_RD;
        end
        default: begin
          state <= ofc_pkg::OFC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt       <= 8'h00;
      op_sector <= 5'h00;
      op_row    <= 4'h0;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      // refused requests only pulse done, never busy
      o_busy <= (!idle || (start && allowed)) && !(erase_end || prog_end);
      o_done <= erase_end || prog_end || (start && !allowed);
      if (start) begin
        op_sector <= i_op_sector;
        op_row    <= i_op_row;
      end
    end
  end

  // every sector protected out of reset
  // master clears protection per sector and may set it again
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_protected <= ofc_pkg::PROT_RESET;
      o_locked    <= ofc_pkg::LOCK_RESET;
    end else begin
      if (i_protect) begin
        o_protected[i_prot_sector] <= 1'b1;
      end else if (i_unprotect) begin
        o_protected[i_prot_sector] <= 1'b0;
      end
      if (i_lock) begin
        o_locked[i_prot_sector] <= 1'b1;
      end
    end
  end

  // data phase: zero-wait reads and buffer writes when idle
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dp_write <= 1'b0;
      dp_addr  <= 13'h0000;
      dp_be    <= 4'h0;
      dp_wr    <= 1'b0;
    end else begin
      dp_wr <= acc_ok && !busy_now && i_hwrite;
      if (acc) begin
        dp_write <= i_hwrite;
        dp_addr  <= off[14:2];
        dp_be    <= lanes(i_hsize, off[1:0]);
      end
    end
  end

  // stall a transfer that meets a running operation
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dp_pend     <= 1'b0;
      err_second  <= 1'b0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      err_second <= 1'b0;
      if (err_second) begin
        o_hreadyout <= 1'b1;
      end else if (acc && out_of_app) begin
        // two-cycle error answer as the bus demands
        o_hreadyout <= 1'b0;
        o_hresp     <= 1'b1;
        err_second  <= 1'b1;
      end else if (acc_stall) begin
        o_hreadyout <= 1'b0;
        o_hresp     <= 1'b0;
        dp_pend     <= 1'b1;
      end else if (resolve) begin
        o_hreadyout <= 1'b1;
        dp_pend     <= 1'b0;
      end else begin
        o_hresp <= 1'b0;
      end
    end
  end

endmodule // ofc_flash_ctrl

// File: common/ofc_pkg.sv
// package: constants and types for the on-chip flash access controller
// assumes one 10 MHz bus clock and an AHB-Lite interconnect that decodes HSEL
package ofc_pkg;
  localparam int unsigned ARRAY_BYTES     = 32768;
  localparam int unsigned APP_BYTES       = 30720;
  localparam int unsigned SECTORS         = 32;
  localparam int unsigned ROWS_PER_SECTOR = 16;
  localparam int unsigned WORDS_PER_ROW   = 16;
  localparam int unsigned ARR_AW          = 13;
  localparam int unsigned BUF_AW          = 4;
  localparam int unsigned SEC_W           = 5;
  localparam int unsigned ROW_W           = 4;
  localparam int unsigned OFF_W           = 15;
  localparam int unsigned APP_SECTORS     = 30;
  localparam logic [OFF_W-1:0] APP_LIMIT  = 15'h7800;
  localparam logic [SEC_W-1:0] APP_SEC_LIM = 5'h1e;
  localparam logic [31:0] ERASED_WORD     = 32'hffffffff;
  localparam logic [31:0] PROT_RESET      = 32'hffffffff;
  localparam logic [31:0] LOCK_RESET      = 32'h00000000;
  localparam logic [7:0]  ERASE_LAST      = 8'hff;
  localparam logic [3:0]  PROG_LAST       = 4'hf;
  localparam logic [2:0]  HSIZE_BYTE      = 3'h0;
  localparam logic [2:0]  HSIZE_HALF      = 3'h1;

  typedef enum logic [1:0] {
    OFC_IDLE    = 2'b00,
    OFC_ERASE   = 2'b01,
    OFC_PROG_RD = 2'b10,
    OFC_PROG_WR = 2'b11
  } ofc_state_t;
endpackage

// File: common/ofc_mem_if.sv
// interface: port of one single-ported word memory
// assumes the controller drives it as master and the memory as slave
`timescale 1ns/1ps
interface ofc_mem_if #(parameter int unsigned AW = 4);
  logic [AW-1:0] addr;
  logic [31:0]   wdata;
  logic [3:0]    be;
  logic          we;
  logic [31:0]   rdata;
  modport ctrl (output addr, output wdata, output be, output we, input rdata);
  modport mem  (input addr, input wdata, input be, input we, output rdata);
endinterface

// File: hdl/ofc_mem.sv
// single-ported word memory with byte enables and registered read data
// assumes one clock; array contents have no reset, only the read register
`timescale 1ns/1ps
module ofc_mem #(
  parameter int unsigned AW = 4
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  ofc_mem_if.mem    port
);
  logic [31:0] store [2**AW];
  logic [31:0] rdata;

  // read every cycle, so data lands with the same edge that takes the address
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= store[port.addr];
    end
  end

  always_ff @(posedge i_core_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (port.we && port.be[b]) begin
        store[port.addr][8*b +: 8] <= port.wdata[8*b +: 8];
      end
    end
  end

  assign port.rdata = rdata;
endmodule // ofc_mem

// File: verification/ofc_checker.sv
// checker: port-level assertions for the flash access controller
// assumes one bus clock and a single slave with hready fed back
`timescale 1ns/1ps
module ofc_checker (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        i_erase_req,
  input wire logic        i_program_req,
  input wire logic [4:0]  i_op_sector,
  input wire logic        i_protect,
  input wire logic        i_lock,
  input wire logic [4:0]  i_prot_sector,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [31:0] o_protected,
  input wire logic [31:0] o_locked
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire take = i_hsel && i_hready && i_htrans[1];
  wire in_app = i_haddr[14:0] < 15'h7800;
  wire idle = !o_busy && o_hreadyout;
  // top two sectors are never modifiable
  wire ok = !o_protected[i_op_sector] && !o_locked[i_op_sector] && i_op_sector < 5'h1e;
  sequence s_err;
    !o_hreadyout && o_hresp ##1 o_hreadyout && o_hresp;
  endsequence
  sequence s_erase;
    o_busy[*8] ##[240:252] o_done;
  endsequence
  prot_reset_a:
    assert property ($rose(i_rst_b) |-> o_protected == 32'hffffffff) else $error("prot reset");
  lock_keep_a:
    assert property ((o_locked & $past(o_locked)) == $past(o_locked)) else $error("lock lost");
  lock_set_a:
    assert property (i_lock |=> o_locked[$past(i_prot_sector)]) else $error("lock set");
  prot_set_a:
    assert property (i_protect |=> o_protected[$past(i_prot_sector)]) else $error("prot set");
  app_ok_a:
    assert property (take && in_app |=> !o_hresp) else $error("bad error");
  area_err_a:
    assert property (take && !in_app && !o_busy |=> s_err) else $error("no area error");
  bus_stall_a:
    assert property (take && o_busy |=> !o_hreadyout) else $error("no stall");
  erase_run_a:
    assert property (i_erase_req && idle && ok |=> s_erase) else $error("erase run");
  prog_run_a:
    assert property (i_program_req && !i_erase_req && idle && ok |=> o_busy ##[28:36] o_done)
      else $error("program run");
  op_refuse_a:
    assert property ((i_erase_req || i_program_req) && idle && !ok |=> !o_busy ##[0:1] o_done)
      else $error("refuse");
endmodule // ofc_checker

bind ofc_flash_ctrl ofc_checker ofc_checker_inst (.i_core_clk, .i_rst_b, .i_hsel, .i_haddr,
  .i_htrans, .i_hready, .o_hreadyout, .o_hresp, .i_erase_req, .i_program_req, .i_op_sector,
  .i_protect, .i_lock, .i_prot_sector, .o_busy, .o_done, .o_protected, .o_locked);

// File: verification/ofc_ahb_master.sv
// partner: bus master model issuing single byte, halfword or word transfers
// assumes it is the only master, hready fed back from hreadyout
`timescale 1ns/1ps
module ofc_ahb_master (
  input  wire logic        i_core_clk,
  input  wire logic        i_hreadyout,
  input  wire logic        i_hresp,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [31:0] o_hwdata
);
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, d, input logic [2:0] s,
                      output logic [31:0] r, output logic rsp);
    @(negedge i_core_clk);
    o_hsel = 1'b1;
    o_htrans = 2'h2;
    o_hwrite = w;
    o_haddr = a;
    o_hsize = s;
    // address held until an edge that sees ready high
    while (!i_hreadyout) @(negedge i_core_clk);
    @(negedge i_core_clk);
    o_hsel = 1'b0;
    o_htrans = 2'h0;
    o_hwdata = d;
    // answer read settled, before the edge that ends the data phase
    while (!i_hreadyout) @(negedge i_core_clk);
    r = i_hrdata;
    rsp = i_hresp;
    @(negedge i_core_clk);
    // released data lines must not keep the old word
    o_hwdata = ~d;
  endtask
endmodule // ofc_ahb_master

// File: verification/testbench.sv
// testbench: scenarios for the flash access controller
// assumes the master model as sole bus user and plain control ports
`timescale 1ns/1ps
module testbench;
  logic        i_core_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_hsel, i_hwrite, i_erase_req, i_program_req, i_unprotect, i_protect, i_lock;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [3:0]  i_op_row;
  logic [4:0]  i_op_sector, i_prot_sector;
  logic [31:0] i_haddr, i_hwdata, rd;
  logic        rsp;
  wire  logic  i_hready, o_hreadyout, o_hresp, o_busy, o_done;
  wire  logic [31:0] o_hrdata, o_protected, o_locked;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  assign i_hready = o_hreadyout;
  always #50 i_core_clk = ~i_core_clk;
  ofc_flash_ctrl ofc_flash_ctrl_inst (.i_core_clk, .i_rst_b, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_erase_req,
    .i_program_req, .i_op_sector, .i_op_row, .i_unprotect, .i_protect, .i_lock, .i_prot_sector,
    .o_busy, .o_done, .o_protected, .o_locked);
  ofc_ahb_master ofc_ahb_master_inst (.i_core_clk, .i_hreadyout(o_hreadyout), .i_hresp(o_hresp),
    .i_hrdata(o_hrdata), .o_hsel(i_hsel), .o_haddr(i_haddr), .o_htrans(i_htrans),
    .o_hwrite(i_hwrite), .o_hsize(i_hsize), .o_hwdata(i_hwdata));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // erases take about 260 cycles; whole run far below this
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [2:0] s = 3'h2);
    ofc_ahb_master_inst.xfer(w, a, d, s, rd, rsp);
  endtask
  task automatic ctl(ref logic s, input logic [4:0] sec);
    @(negedge i_core_clk);
    i_prot_sector = sec;
    s = 1'b1;
    @(negedge i_core_clk);
    s = 1'b0;
  endtask
  task automatic op(ref logic s, input logic [4:0] sec);
    @(negedge i_core_clk);
    i_op_sector = sec;
    s = 1'b1;
    @(negedge i_core_clk);
    s = 1'b0;
    for (int i = 0; i < 400 && o_done !== 1'b1; i++) @(negedge i_core_clk);
    chk("done", 32'h1, {31'h0, o_done});
  endtask
  task automatic t_reset;
    chk("protected", 32'hffffffff, o_protected);
    chk("locked", 32'h0, o_locked);
    $display("reset test done");
  endtask
  task automatic t_commit;
    ctl(i_unprotect, 5'h1);
    op(i_erase_req, 5'h1);
    for (int i = 0; i < 16; i++) bus(1'b1, 32'h400 + 32'(4 * i), 32'ha5c30000 + 32'(i));
    bus(1'b0, 32'h404, 32'h0);
    chk("array after buffer write", 32'hffffffff, rd);
    op(i_program_req, 5'h1);
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 32'h400 + 32'(4 * i), 32'h0);
      chk("programmed word", 32'ha5c30000 + 32'(i), rd);
    end
    $display("commit test done");
  endtask
  task automatic t_lanes;
    bus(1'b1, 32'h441, 32'h00003c00, 3'h0);
    bus(1'b1, 32'h446, 32'h12340000, 3'h1);
    i_op_row = 4'h1;
    op(i_program_req, 5'h1);
    i_op_row = 4'h0;
    bus(1'b0, 32'h440, 32'h0);
    chk("byte lane word", 32'ha5c33c00, rd);
    bus(1'b0, 32'h444, 32'h0);
    chk("half lane word", 32'h12340001, rd);
    $display("lanes test done");
  endtask
  task automatic t_rerun;
    @(negedge i_core_clk);
    i_rst_b = 1'b0;
    repeat (3) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    chk("protected after rerun", 32'hffffffff, o_protected);
    chk("rerun resp", 32'h0, {31'h0, o_hresp});
    $display("rerun test done");
  endtask
  task automatic t_stall;
    ctl(i_unprotect, 5'h2);
    fork
      op(i_erase_req, 5'h2);
      begin
        repeat (3) @(negedge i_core_clk);
        bus(1'b0, 32'h808, 32'h0);
      end
    join
    chk("stalled read", 32'hffffffff, rd);
    chk("stalled resp", 32'h0, {31'h0, rsp});
    $display("stall test done");
  endtask
  task automatic t_guard;
    ctl(i_protect, 5'h1);
    op(i_erase_req, 5'h1);
    bus(1'b0, 32'h400, 32'h0);
    chk("protected word", 32'ha5c30000, rd);
    chk("protected resp", 32'h0, {31'h0, rsp});
    ctl(i_unprotect, 5'h1);
    ctl(i_lock, 5'h1);
    chk("lock bits", 32'h2, o_locked);
    op(i_erase_req, 5'h1);
    bus(1'b0, 32'h400, 32'h0);
    chk("locked word", 32'ha5c30000, rd);
    $display("guard test done");
  endtask
  task automatic t_area;
    bus(1'b0, 32'h77fc, 32'h0);
    chk("last app resp", 32'h0, {31'h0, rsp});
    bus(1'b0, 32'h7800, 32'h0);
    chk("reserved resp", 32'h1, {31'h0, rsp});
    ctl(i_unprotect, 5'h1e);
    op(i_erase_req, 5'h1e);
    $display("area test done");
  endtask
  initial begin
    {i_erase_req, i_program_req, i_unprotect, i_protect, i_lock} = 5'h0;
    i_op_sector = 5'h0;
    i_prot_sector = 5'h0;
    i_op_row = 4'h0;
    repeat (20) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    t_reset;
    t_commit;
    t_lanes;
    t_stall;
    t_guard;
    t_area;
    t_rerun;
    complete_run;
  end
endmodule // testbench
